// >>> rtl/inc_dec_if.sv
// decoded fields passed from the decoder to the execute stage
`timescale 1ns/10ps
`default_nettype none
interface inc_dec_if;
   logic       is_inc;
   logic       is_skip;
   logic       dest_f;
   logic [4:0] addr;
   logic       is_port;
   logic       is_timer;
   modport dec (output is_inc, is_skip, dest_f, addr, is_port, is_timer);
   modport exe (input is_inc, is_skip, dest_f, addr, is_port, is_timer);
endinterface
`default_nettype wire

// >>> rtl/inc_decoder.sv
// opcode decoder for the two increment instructions
`timescale 1ns/10ps
`default_nettype none
module inc_decoder
(
   input  wire logic [11:0] instr_i,
   inc_dec_if.dec           dec
);
   // field decode
   always_comb
   begin
      dec.is_inc   = instr_i[inc_pkg::OP_MSB:inc_pkg::OP_LSB] == inc_pkg::INC_OP;
      dec.is_skip  = instr_i[inc_pkg::OP_MSB:inc_pkg::OP_LSB] == inc_pkg::INCSKIP_OP;
      dec.dest_f   = instr_i[inc_pkg::DEST_BIT];
      dec.addr     = instr_i[inc_pkg::ADDR_MSB:0];
      dec.is_port  = (instr_i[4:0] >= inc_pkg::PORT_LO_ADDR)
                     && (instr_i[4:0] <= inc_pkg::PORT_HI_ADDR);
      dec.is_timer = instr_i[4:0] == inc_pkg::TMR_ADDR;
   end
endmodule
`default_nettype wire

// >>> rtl/inc_pkg.sv
// constants for the increment and increment-skip execute block
package inc_pkg;
   localparam int          WORD_W        = 12;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 5;
   localparam int          DEST_BIT      = 5;
   localparam int          ADDR_MSB      = 4;
   localparam int          OP_MSB        = 11;
   localparam int          OP_LSB        = 6;
   localparam logic [5:0]  INC_OP        = 6'h0A;  // 0010 10
   localparam logic [5:0]  INCSKIP_OP    = 6'h0F;  // 0011 11
   localparam logic [11:0] NOP_WORD      = 12'h000;
   localparam logic [4:0]  TMR_ADDR      = 5'h01;
   localparam logic [4:0]  PORT_LO_ADDR  = 5'h05;
   localparam logic [4:0]  PORT_HI_ADDR  = 5'h07;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [7:0]  ONE_BYTE      = 8'h01;
endpackage

// >>> rtl/increment_skip_exec.sv
// execute stage for the plain increment and the increment-skip instructions
`timescale 1ns/10ps
`default_nettype none
module increment_skip_exec
(
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        cycle_en_i,     // one instruction cycle
   input  wire logic [11:0] instr_i,        // instruction in execute
   input  wire logic [7:0]  file_rdata_i,   // addressed register contents
   input  wire logic [7:0]  port_pins_i,    // pin levels of addressed port
   input  wire logic        psa_timer_i,    // prescaler assigned to timer
   input  wire logic        zero_flag_i,    // current zero flag
   output logic [4:0]       file_addr_o,
   output logic [7:0]       file_wdata_o,
   output logic             file_we_o,
   output logic [7:0]       acc_wdata_o,
   output logic             acc_we_o,
   output logic             zero_flag_o,
   output logic             zero_we_o,
   output logic             skip_o,         // prefetch discarded
   output logic             nop_exec_o,     // no-operation cycle running
   output logic             prescaler_clr_o
);
   //--------------------------------------------------------------
   // decode
   //--------------------------------------------------------------
   inc_dec_if dec_bus ();
   logic [7:0] pin_q1;
   logic [7:0] pin_q2;
   logic [7:0] operand;
   logic [7:0] result;
   logic       active;
   logic       skip_q;
   logic       zero_res;

   // replacement word when the prefetched one is discarded
   logic [11:0] exec_word;
   assign exec_word = skip_q ? inc_pkg::NOP_WORD : instr_i;

   inc_decoder u_dec
   (
      .instr_i (exec_word),
      .dec     (dec_bus)
   );

   // pin levels pass two flops
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         pin_q1 <= inc_pkg::ZERO_BYTE;
         pin_q2 <= inc_pkg::ZERO_BYTE;
      end
      else
      begin
         pin_q1 <= port_pins_i;
         pin_q2 <= pin_q1;
      end
   end

   //--------------------------------------------------------------
   // datapath
   //--------------------------------------------------------------
   // zero test shared by the flag and the skip
   function automatic logic is_zero_byte(input logic [7:0] v);
      is_zero_byte = v == inc_pkg::ZERO_BYTE;
   endfunction

   // operand select, increment and zero test
   always_comb
   begin
      operand  = dec_bus.is_port ? pin_q2 : file_rdata_i;
      result   = operand + inc_pkg::ONE_BYTE;
      active   = cycle_en_i && (dec_bus.is_inc || dec_bus.is_skip);
      zero_res = is_zero_byte(result);
   end

   // register file and accumulator writes
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         file_addr_o  <= 5'h00;
         file_wdata_o <= inc_pkg::ZERO_BYTE;
         file_we_o    <= 1'b0;
         acc_wdata_o  <= inc_pkg::ZERO_BYTE;
         acc_we_o     <= 1'b0;
      end
      else
      begin
         file_addr_o  <= dec_bus.addr;
         file_wdata_o <= result;
         acc_wdata_o  <= result;
         file_we_o    <= active && dec_bus.dest_f;
         acc_we_o     <= active && !dec_bus.dest_f;
      end
   end

   // zero flag only from the plain increment
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         zero_flag_o <= 1'b0;
         zero_we_o   <= 1'b0;
      end
      else
      begin
         zero_we_o <= cycle_en_i && dec_bus.is_inc;
         if (cycle_en_i && dec_bus.is_inc)
            zero_flag_o <= zero_res;
         else
            zero_flag_o <= zero_flag_i;
      end
   end

   // skip: next cycle executes a no-operation
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         skip_q <= 1'b0;
      else if (cycle_en_i)
         skip_q <= dec_bus.is_skip && zero_res;
   end

   // skip and no-operation pulses out
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         skip_o     <= 1'b0;
         nop_exec_o <= 1'b0;
      end
      else
      begin
         skip_o     <= cycle_en_i && dec_bus.is_skip && zero_res;
         nop_exec_o <= cycle_en_i && skip_q;
      end
   end

   // prescaler clear on timer write back
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         prescaler_clr_o <= 1'b0;
      else
         prescaler_clr_o <= active && dec_bus.dest_f && dec_bus.is_timer
                            && psa_timer_i;
   end

   //--------------------------------------------------------------
   // check helpers
   //--------------------------------------------------------------
   // a reported skip, held until the next instruction cycle
   logic skip_due_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         skip_due_q <= 1'b0;
      else if (cycle_en_i)
         skip_due_q <= 1'b0;
      else if (skip_o)
         skip_due_q <= 1'b1;
   end

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   // skip taken in this cycle
   sequence s_skip_hit;
      cycle_en_i && dec_bus.is_skip && zero_res;
   endsequence

   // first instruction cycle after a taken skip
   sequence s_replaced_slot;
      cycle_en_i && (skip_o || skip_due_q);
   endsequence

   chk_skip_nop_follows: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_replaced_slot |-> !active)
      else $error("prefetched word not replaced by no-operation");
   chk_skip_two_cycles: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_replaced_slot |=> nop_exec_o && !acc_we_o && !file_we_o)
      else $error("skip did not add a no-operation cycle");
   chk_no_skip_plain: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      cycle_en_i && dec_bus.is_skip && result != inc_pkg::ZERO_BYTE |=> !skip_o)
      else $error("skip taken on nonzero result");
   chk_acc_dest: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      active && !dec_bus.dest_f |=> acc_we_o && !file_we_o && acc_wdata_o == $past(result))
      else $error("accumulator destination wrong");
   chk_file_dest: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      active && dec_bus.dest_f |=> file_we_o && !acc_we_o
                                   && file_addr_o == $past(dec_bus.addr))
      else $error("file destination wrong");
   chk_inc_value: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      active && !dec_bus.is_port |=> file_wdata_o == $past(file_rdata_i) + 8'h01)
      else $error("increment value wrong");
   chk_zero_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      cycle_en_i && dec_bus.is_inc |=> zero_we_o
                                       && zero_flag_o == ($past(operand) == 8'hFF))
      else $error("zero flag wrong");
   chk_skip_flags: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      cycle_en_i && dec_bus.is_skip |=> !zero_we_o && zero_flag_o == $past(zero_flag_i))
      else $error("skip variant touched status");
   chk_port_operand: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      active && dec_bus.is_port |=> file_wdata_o == $past(pin_q2) + 8'h01)
      else $error("port operand not from pins");
   chk_presc_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      prescaler_clr_o |-> $past(psa_timer_i) && file_we_o && file_addr_o == inc_pkg::TMR_ADDR)
      else $error("prescaler clear without timer write");
   chk_skip_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_skip_hit |=> skip_o)
      else $error("taken skip not reported");
   chk_nop_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      nop_exec_o |-> !zero_we_o && !prescaler_clr_o)
      else $error("no-operation cycle changed state");
endmodule
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the increment and increment-skip execute block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin comparisons++; if ((got) !== (ex)) begin err_total++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb;
   logic        sys_clk_i, resetn_i, cycle_en_i, psa_timer_i, zero_flag_i;
   logic [11:0] instr_i;
   logic [7:0]  file_rdata_i, port_pins_i, file_wdata_o, acc_wdata_o;
   logic [4:0]  file_addr_o;
   logic        file_we_o, acc_we_o, zero_flag_o, zero_we_o, skip_o, nop_exec_o, prescaler_clr_o;
   int          err_total = 0;
   int          comparisons = 0;

   increment_skip_exec i_dut
   (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cycle_en_i(cycle_en_i),
      .instr_i(instr_i), .file_rdata_i(file_rdata_i), .port_pins_i(port_pins_i),
      .psa_timer_i(psa_timer_i), .zero_flag_i(zero_flag_i), .file_addr_o(file_addr_o),
      .file_wdata_o(file_wdata_o), .file_we_o(file_we_o), .acc_wdata_o(acc_wdata_o),
      .acc_we_o(acc_we_o), .zero_flag_o(zero_flag_o), .zero_we_o(zero_we_o),
      .skip_o(skip_o), .nop_exec_o(nop_exec_o), .prescaler_clr_o(prescaler_clr_o)
   );

   // -----------------------------------------------
   // clock, tasks
   // -----------------------------------------------
   // 40 MHz clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one enable pulse, outputs settled afterwards
   task run(input logic [11:0] w, input logic [7:0] rd);
      @(posedge sys_clk_i);
      #1;
      cycle_en_i = 1'b1;
      instr_i = w;
      file_rdata_i = rd;
      @(posedge sys_clk_i);
      #1;
      cycle_en_i = 1'b0;
   endtask

   task t_plain;
      for (int d = 0; d < 2; d++)
      begin
         run({inc_pkg::INC_OP, d[0], 5'h1F}, d[0] ? 8'hFF : 8'h05);
         `CHK("addr", 5'h1F, file_addr_o)
         `CHK("acc_we", !d[0], acc_we_o)
         `CHK("file_we", d[0], file_we_o)
         `CHK("data", d[0] ? 8'h00 : 8'h06, d[0] ? file_wdata_o : acc_wdata_o)
         `CHK("z_we", 1'b1, zero_we_o)
         `CHK("z", d[0], zero_flag_o)
      end
      $display("plain increment done");
   endtask

   task t_skip;
      zero_flag_i = 1'b1;
      run({inc_pkg::INCSKIP_OP, 1'b0, 5'h09}, 8'h41);
      `CHK("acc", 8'h42, acc_wdata_o)
      `CHK("skip", 1'b0, skip_o)
      `CHK("z_we", 1'b0, zero_we_o)
      run({inc_pkg::INCSKIP_OP, 1'b1, 5'h03}, 8'hFF);
      `CHK("wdata", 8'h00, file_wdata_o)
      `CHK("skip", 1'b1, skip_o)
      `CHK("z", 1'b1, zero_flag_o)
      run({inc_pkg::INC_OP, 1'b0, 5'h03}, 8'h10);
      `CHK("acc_we", 1'b0, acc_we_o)
      `CHK("nop", 1'b1, nop_exec_o)
      run({inc_pkg::INC_OP, 1'b0, 5'h03}, 8'h10);
      `CHK("acc_we", 1'b1, acc_we_o)
      `CHK("nop", 1'b0, nop_exec_o)
      run(12'h0E9, 8'h10);
      `CHK("other", 2'b00, {acc_we_o, file_we_o})
      zero_flag_i = 1'b0;
      $display("skip variant done");
   endtask

   task t_port_timer;
      port_pins_i = 8'h3C;
      repeat (3) @(posedge sys_clk_i);
      run({inc_pkg::INC_OP, 1'b1, 5'h05}, 8'hC3);
      `CHK("port", 8'h3D, file_wdata_o)
      for (int k = 0; k < 4; k++)
      begin
         psa_timer_i = (k != 1);
         run({k[1] ? inc_pkg::INCSKIP_OP : inc_pkg::INC_OP, k != 2, inc_pkg::TMR_ADDR}, 8'h07);
         `CHK("pre_clr", k != 1 && k != 2, prescaler_clr_o)
      end
      $display("port and timer done");
   endtask

   // a reset in mid-run drops a pending skip
   task t_reset_mid;
      run({inc_pkg::INCSKIP_OP, 1'b0, 5'h0A}, 8'hFF);
      `CHK("skip", 1'b1, skip_o)
      resetn_i = 1'b0;
      @(posedge sys_clk_i);
      #1;
      `CHK("rst_out", 5'h00, {skip_o, acc_we_o, file_we_o, zero_we_o, nop_exec_o})
      resetn_i = 1'b1;
      run({inc_pkg::INC_OP, 1'b0, 5'h0A}, 8'h20);
      `CHK("acc", 8'h21, acc_wdata_o)
      `CHK("nop", 1'b0, nop_exec_o)
      `CHK("acc_we", 1'b1, acc_we_o)
      $display("mid-run reset done");
   endtask

   // -----------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------
   // reset then the tests
   initial
   begin
      resetn_i = 1'b0;
      cycle_en_i = 1'b0;
      instr_i = 12'h000;
      file_rdata_i = 8'h00;
      port_pins_i = 8'h00;
      psa_timer_i = 1'b0;
      zero_flag_i = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      resetn_i = 1'b1;
      t_plain;
      t_skip;
      t_port_timer;
      t_reset_mid;
      close_out;
   end

   // cuts a hang short
   initial
   begin
      #(25 * 500);
      err_total++;
      close_out;
   end
endmodule
`default_nettype wire
